// file: rtl/lsl_led_driver.sv
// Purpose: drive link, rate and traffic indicators on shared event pins
// Assumes: status inputs are synchronous to mclk; strap and pin inputs are not
// Notes: indicator high means lamp on; pins index 0 traffic, 1 rate, 2 link
`timescale 1ns/1ps
`include "lsl_regs.svh"

module lsl_led_driver #(
	parameter int unsigned BLINK_CYCLES = `LSL_BLINK_CYCLES,
	parameter int unsigned STRETCH_TICKS = `LSL_STRETCH_TICKS
) (
	input logic mclk,
	input logic nrst,
	input logic led_mode_strap,
	input logic mode3_sel,
	input logic link_good,
	input logic speed_100,
	input logic full_duplex,
	input logic tx_active,
	input logic rx_active,
	input logic collision,
	input logic [2:0] ovr_en,
	input logic [2:0] ovr_val,
	input logic [2:0] pin_event_sel,
	input logic [2:0] event_out,
	input logic [2:0] event_oe,
	output logic [2:0] event_in,
	input logic [2:0] ind_pin_in,
	output logic [2:0] ind_pin_out,
	output logic [2:0] ind_pin_oe,
	output logic [1:0] active_mode
);
	localparam int TI = `LSL_IDX_TRAFFIC;
	localparam int RI = `LSL_IDX_RATE;
	localparam int LI = `LSL_IDX_LINK;

	// reset release through two flops
	logic rst_meta_ff;
	logic rst_n;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_ff <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n <= rst_meta_ff;
		end
	end

	// strap synchroniser runs through reset, so the level is settled at capture
	logic strap_meta_ff;
	logic strap_sync_ff;
	logic strap_done_ff;
	logic strap_link_ff;
	always_ff @(posedge mclk) begin
		strap_meta_ff <= led_mode_strap;
		strap_sync_ff <= strap_meta_ff;
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			strap_done_ff <= 1'b0;
			strap_link_ff <= 1'b0;
		end else if (!strap_done_ff) begin
			strap_done_ff <= 1'b1;
			strap_link_ff <= (strap_sync_ff == `LSL_STRAP_LINK_MODE);
		end
	end

	// mode selection: configured mode 3 overrides the strap
	lsl_pkg::lsl_mode_e cur_mode;
	assign cur_mode = mode3_sel ? lsl_pkg::mode_dup :
		strap_link_ff ? lsl_pkg::mode_link : lsl_pkg::mode_col;

	logic [1:0] mode_ff;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff <= `LSL_MODE_RST;
		end else begin
			mode_ff <= cur_mode;
		end
	end
	assign active_mode = mode_ff;

	// status qualification
	wire activity = tx_active | rx_active;
	wire col_qual = collision & ~full_duplex;

	logic blink_off;
	logic blinking;
	lsl_blink #(
		.BLINK_CYCLES(BLINK_CYCLES),
		.STRETCH_TICKS(STRETCH_TICKS)
	) u_blink (
		.mclk(mclk),
		.rst_n(rst_n),
		.activity(activity),
		.blink_off(blink_off),
		.blinking(blinking)
	);

	// per-mode indicator functions
	logic link_fn;
	logic traffic_fn;
	always_comb begin
		case (cur_mode)
			lsl_pkg::mode_link: begin
				link_fn = link_good;
				traffic_fn = activity;
			end
			lsl_pkg::mode_col: begin
				link_fn = link_good & ~blink_off;
				traffic_fn = col_qual;
			end
			lsl_pkg::mode_dup: begin
				link_fn = link_good & ~blink_off;
				traffic_fn = full_duplex;
			end
			default: begin
				link_fn = link_good;
				traffic_fn = 1'b0;
			end
		endcase
	end

	wire [2:0] func_vec = {link_fn, speed_100, traffic_fn};
	wire [2:0] nxt_ind = (ovr_en & ovr_val) | (~ovr_en & func_vec);

	logic [2:0] ind_ff;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ind_ff <= `LSL_IND_RST;
		end else begin
			ind_ff <= nxt_ind;
		end
	end

	// shared pins: indicator drive or event function
	logic [2:0] pin_meta_ff;
	logic [2:0] pin_sync_ff;
	for (genvar i = 0; i < `LSL_NUM_PINS; i++) begin : g_pin
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				pin_meta_ff[i] <= 1'b0;
				pin_sync_ff[i] <= 1'b0;
			end else begin
				pin_meta_ff[i] <= ind_pin_in[i];
				pin_sync_ff[i] <= pin_meta_ff[i];
			end
		end
		assign ind_pin_out[i] = pin_event_sel[i] ? event_out[i] : ind_ff[i];
		assign ind_pin_oe[i] = pin_event_sel[i] ? event_oe[i] : 1'b1;
		assign event_in[i] = pin_sync_ff[i];
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_mode_three: assert property (mode3_sel |=> mode_ff == lsl_pkg::mode_dup)
		else $error("configured mode 3 not taken");
	a_strap_held: assert property (strap_done_ff |=> $stable(strap_link_ff))
		else $error("strap mode changed after capture");
	a_link_plain: assert property ((cur_mode == lsl_pkg::mode_link && !ovr_en[LI])
		|=> ind_ff[LI] == $past(link_good))
		else $error("mode 1 link lamp does not follow link");
	a_link_blink: assert property ((cur_mode != lsl_pkg::mode_link && !ovr_en[LI] && link_good)
		|=> ind_ff[LI] == !$past(blink_off))
		else $error("link lamp not blinking with activity");
	a_link_dark: assert property ((!link_good && !ovr_en[LI]) |=> !ind_ff[LI])
		else $error("link lamp lit without link");
	a_rate_speed: assert property (!ovr_en[RI] |=> ind_ff[RI] == $past(speed_100))
		else $error("rate lamp does not follow speed");
	a_traffic_act: assert property ((cur_mode == lsl_pkg::mode_link && !ovr_en[TI])
		|=> ind_ff[TI] == $past(tx_active || rx_active))
		else $error("activity lamp wrong in mode 1");
	a_traffic_col: assert property ((cur_mode == lsl_pkg::mode_col && !ovr_en[TI])
		|=> ind_ff[TI] == $past(collision && !full_duplex))
		else $error("collision lamp wrong in mode 2");
	a_traffic_dup: assert property ((cur_mode == lsl_pkg::mode_dup && !ovr_en[TI])
		|=> ind_ff[TI] == $past(full_duplex))
		else $error("duplex lamp wrong in mode 3");
	a_col_fdx: assert property ((full_duplex && cur_mode == lsl_pkg::mode_col && !ovr_en[TI])
		|=> !ind_ff[TI])
		else $error("collision shown in full duplex");
	a_pin_share: assert property (ind_pin_oe == ((pin_event_sel & event_oe) | ~pin_event_sel)
		&& ind_pin_out == ((pin_event_sel & event_out) | (~pin_event_sel & ind_ff)))
		else $error("shared pin mux wrong");
	a_burst_stretch: assert property (activity ##1 !activity |-> blinking [*3])
		else $error("short burst not stretched");

	c_mode1_act: cover property (cur_mode == lsl_pkg::mode_link && activity ##1 ind_ff[TI]);
	c_mode2_col: cover property (cur_mode == lsl_pkg::mode_col && col_qual ##1 ind_ff[TI]);
	c_mode3_dup: cover property (cur_mode == lsl_pkg::mode_dup && full_duplex ##1 ind_ff[TI]);
	c_link_blink: cover property (link_good && blink_off && cur_mode != lsl_pkg::mode_link);
	c_event_pin: cover property (pin_event_sel != 3'h0 && event_oe != 3'h0);

endmodule : lsl_led_driver

// file: rtl/lsl_regs.svh
// Purpose: constants of the status indicator driver
// Assumes: 25 MHz mclk
// Notes: timing figures kept in their own unit, cycle counts derived
`ifndef LSL_REGS_SVH
`define LSL_REGS_SVH

// indicator positions on the shared pins
`define LSL_IDX_TRAFFIC 0
`define LSL_IDX_RATE 1
`define LSL_IDX_LINK 2
`define LSL_NUM_PINS 3

// clock and blink timing
`define LSL_MCLK_HZ 25000000
`define LSL_BLINK_HALF_MS 50
`define LSL_BLINK_CYCLES ((`LSL_BLINK_HALF_MS * `LSL_MCLK_HZ) / 1000)
`define LSL_STRETCH_TICKS 3

// strap level that selects the plain link mode
`define LSL_STRAP_LINK_MODE 1'b1

// reset values
`define LSL_IND_RST 3'h0
`define LSL_MODE_RST 2'h0

`endif

// file: rtl/lsl_pkg.sv
// Purpose: types of the status indicator driver
// Assumes: nothing
// Notes: mode encodings follow declaration order from 0: link 0, collision 1, duplex 2
package lsl_pkg;

	typedef enum logic [1:0] {
		mode_link,
		mode_col,
		mode_dup
	} lsl_mode_e;

endpackage : lsl_pkg

// file: rtl/lsl_blink.sv
// Purpose: blink timebase with activity stretch
// Assumes: activity is synchronous to mclk
// Notes: blink_off high means the lamp is dark for this half period
`timescale 1ns/1ps
`include "lsl_regs.svh"

module lsl_blink #(
	parameter int unsigned BLINK_CYCLES = `LSL_BLINK_CYCLES,
	parameter int unsigned STRETCH_TICKS = `LSL_STRETCH_TICKS
) (
	input logic mclk,
	input logic rst_n,
	input logic activity,
	output logic blink_off,
	output logic blinking
);
	localparam int CW = $clog2(BLINK_CYCLES + 1);
	localparam int SW = $clog2(STRETCH_TICKS + 1);

	if (BLINK_CYCLES < 2 || STRETCH_TICKS < 2) begin : g_chk
		$error("lsl_blink: BLINK_CYCLES and STRETCH_TICKS must be at least 2");
	end

	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;
	logic [SW-1:0] stretch_ff;
	logic [SW-1:0] nxt_stretch;
	logic phase_ff;
	wire tick = (cnt_ff == CW'(BLINK_CYCLES - 1));

	// free running half-period counter
	assign nxt_cnt = tick ? '0 : cnt_ff + CW'(1);
	// bursts keep blinking alive for several half periods
	assign nxt_stretch = activity ? SW'(STRETCH_TICKS) :
		(tick && stretch_ff != '0) ? stretch_ff - SW'(1) : stretch_ff;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= '0;
			stretch_ff <= '0;
			phase_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			stretch_ff <= nxt_stretch;
			phase_ff <= tick ? ~phase_ff : phase_ff;
		end
	end

	assign blinking = (stretch_ff != '0);
	assign blink_off = blinking & phase_ff;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_stretch_load: assert property (activity |=> stretch_ff == SW'(STRETCH_TICKS))
		else $error("stretch not reloaded by activity");
	a_phase_tick: assert property (tick |=> phase_ff != $past(phase_ff))
		else $error("blink phase did not toggle on tick");

endmodule : lsl_blink

// file: verification/lsl_led_model.sv
// Purpose: lamps and pull-ups on the three shared indicator pins
// Assumes: each pin has a pull-up, as the shared event pins do
// Notes: a released pin reads high
`timescale 1ns/1ps

module lsl_led_model (
	input wire logic [2:0] pin_out,
	input wire logic [2:0] pin_oe,
	output logic [2:0] pin_lvl
);
	// driven pins follow the driver, released pins go to the pull-up level
	assign pin_lvl = (pin_out & pin_oe) | ~pin_oe;
endmodule : lsl_led_model

// file: verification/tb_top.sv
// Purpose: self-checking bench of the status indicator driver
// Assumes: short blink half period of 8 cycles
// Notes: driver queues notes {kind, value}; a watcher compares them
`timescale 1ns/1ps

module tb_top;
	logic mclk = 1'b0, nrst = 1'b0, strap = 1'b1, m3 = 1'b0, link = 1'b0, spd = 1'b0;
	logic fdx = 1'b0, tx = 1'b0, rx = 1'b0, col = 1'b0;
	logic [2:0] ovr_en = 3'h0, ovr_val = 3'h0, esel = 3'h0, eout = 3'h0, eoe = 3'h0;
	logic [2:0] pin_lvl, ev_in, pout, poe, got;
	logic [1:0] amode;
	logic [3:0] r;
	logic [4:0] note;
	logic [4:0] q[$];
	int fails = 0, n_checks = 0, cyc = 0, seed = 15826;
	event ev;

	lsl_led_driver #(.BLINK_CYCLES(8), .STRETCH_TICKS(3)) u_lsl_led_driver (.mclk(mclk), .nrst(nrst),
		.led_mode_strap(strap), .mode3_sel(m3), .link_good(link), .speed_100(spd), .full_duplex(fdx),
		.tx_active(tx), .rx_active(rx), .collision(col), .ovr_en(ovr_en), .ovr_val(ovr_val),
		.pin_event_sel(esel), .event_out(eout), .event_oe(eoe), .event_in(ev_in), .ind_pin_in(pin_lvl),
		.ind_pin_out(pout), .ind_pin_oe(poe), .active_mode(amode));
	lsl_led_model u_lsl_led_model (.pin_out(pout), .pin_oe(poe), .pin_lvl(pin_lvl));

	initial forever #20 mclk = ~mclk;

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict

	task automatic cmp3(input logic [2:0] g, input logic [2:0] e);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("mismatch at %0t: got %b expected %b", $time, g, e);
		end
	endtask : cmp3

	// kind 0 pin out, 1 pin enable, 2 event input, 3 mode
	task automatic expect3(input logic [1:0] k, input logic [2:0] v);
		q.push_back({k, v});
		-> ev;
	endtask : expect3

	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask : step

	task automatic do_reset(input logic s);
		@(posedge mclk);
		nrst <= 1'b0;
		strap <= s;
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		step(8);
	endtask : do_reset

	initial forever begin
		@ev;
		while (q.size() > 0) begin
			note = q.pop_front();
			case (note[4:3])
				2'h0: got = pout;
				2'h1: got = poe;
				2'h2: got = ev_in;
				default: got = {1'b0, amode};
			endcase
			cmp3(got, note[2:0]);
		end
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			$display("mismatch at %0t: run too long", $time);
			print_verdict();
		end
	end

	initial begin
		do_reset(1'b1);
		expect3(2'h3, {1'b0, lsl_pkg::mode_link});
		expect3(2'h0, 3'h0);
		expect3(2'h1, 3'h7);
		for (int i = 0; i < 8; i++) begin
			r = 4'($random(seed));
			@(posedge mclk);
			{link, spd, tx, rx} <= r;
			step(2);
			expect3(2'h0, {r[3], r[2], r[1] | r[0]});
		end
		$display("test mode one done");
		@(posedge mclk);
		ovr_en <= 3'h5;
		ovr_val <= 3'h4;
		step(2);
		expect3(2'h0, {1'b1, spd, 1'b0});
		@(posedge mclk);
		{ovr_en, m3, fdx, tx, rx, link} <= {3'h0, 5'h1_9};
		step(30);
		expect3(2'h3, {1'b0, lsl_pkg::mode_dup});
		expect3(2'h0, {1'b1, spd, 1'b1});
		@(posedge mclk);
		{esel, eoe, eout} <= {3'h3, 3'h1, 3'h0};
		step(3);
		expect3(2'h1, 3'h5);
		expect3(2'h0, 3'h4);
		expect3(2'h2, 3'h6);
		$display("test mode three and event pins done");
		@(posedge mclk);
		esel <= 3'h0;
		m3 <= 1'b0;
		do_reset(1'b0);
		expect3(2'h3, {1'b0, lsl_pkg::mode_col});
		@(posedge mclk);
		col <= 1'b1;
		step(2);
		expect3(2'h0, {1'b1, spd, 1'b0});
		@(posedge mclk);
		fdx <= 1'b0;
		step(2);
		expect3(2'h0, {1'b1, spd, 1'b1});
		@(posedge mclk);
		col <= 1'b0;
		tx <= 1'b1;
		@(posedge mclk);
		tx <= 1'b0;
		for (int j = 0; j < 100 && pout[2] !== 1'b0; j++)
			step(1);
		expect3(2'h0, {1'b0, spd, 1'b0});
		step(100);
		expect3(2'h0, {1'b1, spd, 1'b0});
		$display("test mode two and blink done");
		step(1);
		print_verdict();
	end
endmodule : tb_top
